// ### fcp_pkg.sv
// Package for the four-channel modulated DAC output block.
// Assumes a single core clock; used by fcp_top, its checker and tb_top.
package fcp_pkg;
  // Register map on the plain register port
  localparam logic [1:0] ADDR_CTRL_A = 2'h0;
  localparam logic [1:0] ADDR_CTRL_B = 2'h1;
  localparam logic [1:0] ADDR_DBUF   = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  // mod_control_a fields
  localparam int RES0_BIT  = 0;
  localparam int RES1_BIT  = 1;
  localparam int ABORT_BIT = 2;
  localparam int DIV_BIT   = 3;
  // mod_control_b fields
  localparam int HALF_BIT  = 0;
  localparam int CHS_LO    = 1;
  localparam int RUN_LO    = 4;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  // Timing: counter spans 2^16 core cycles at most
  localparam int CNT_W     = 16;
  localparam int SUB12_W   = 4;
  localparam int SUB14_W   = 6;
  localparam int LOW_W     = 8;
  localparam int UP12_W    = 4;
  localparam int UP14_W    = 6;
  localparam logic [CNT_W-1:0] CNT_ONES = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : fcp_pkg

// ### fcp_top.sv
// Four-channel modulated output unit, active-low outputs.
// Assumes a register master on core_clk and an external RC filter.
`timescale 1ns/1ps
// Notes on behaviour
// - Four channels, two also 14-bit capable
// - Channels 0,1 select 12 or 14 bits
// - Channels 2,3 fixed at 12-bit timing
// - Outputs active low, idle high
// - Outputs held high during STOP
// - STOP holds both control registers at reset
// - 12-bit period 2^13/2^14, 16 sub-periods
// - 14-bit period 2^15/2^16, 64 sub-periods
// - Low byte n gives n units low
// - 12-bit upper m adds m pulses
// - 12-bit additional-pulse bit-to-slot mapping
// - 14-bit upper m adds m pulses
// - 14-bit additional-pulse bit-to-slot mapping
// - Counter held at ones while idle
// - Latch loads only when counter all ones
// - Abort forces high; run starts channel
module fcp_top #(
  parameter int NCH = 4
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       stop_mode,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            mod_out_ch0,
  output logic            mod_out_ch1,
  output logic            mod_out_ch2,
  output logic            mod_out_ch3
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]             mod_control_a_q;
  logic [7:0]             mod_control_b_q;
  logic [7:0]             mod_data_buffer_q;
  logic                   stop_s1_q;
  logic                   stop_s2_q;
  logic [fcp_pkg::CNT_W-1:0] cnt_q;
  logic [7:0]             buf_lo_q  [NCH];
  logic [5:0]             buf_hi_q  [NCH];
  logic [7:0]             lat_lo_q  [NCH];
  logic [5:0]             mod_latch_upper_q [NCH];
  logic [NCH-1:0]         out_q;
  logic                   mod_abort;
  logic                   clock_halve_select;
  logic [1:0]             channel_resolution_select;
  logic [1:0]             channel_latch_select;
  logic                   latch_half_select;
  logic [3:0]             channel_run;
  logic                   cnt_hold;
  logic                   any_zero_lo;

  assign mod_abort                 = mod_control_a_q[fcp_pkg::ABORT_BIT];
  assign clock_halve_select        = mod_control_a_q[fcp_pkg::DIV_BIT];
  assign channel_resolution_select = {mod_control_a_q[fcp_pkg::RES1_BIT],
                                      mod_control_a_q[fcp_pkg::RES0_BIT]};
  assign latch_half_select         = mod_control_b_q[fcp_pkg::HALF_BIT];
  assign channel_latch_select      = mod_control_b_q[fcp_pkg::CHS_LO +: 2];
  assign channel_run               = mod_control_b_q[fcp_pkg::RUN_LO +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // STOP pin from outside the domain: two flops first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end else begin
      stop_s1_q <= stop_mode;
      stop_s2_q <= stop_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; held at reset value during STOP so that
  // they come back initialised on return to normal mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_control_a_q <= fcp_pkg::CTRL_A_RST;
      mod_control_b_q <= fcp_pkg::CTRL_B_RST;
    end else if (stop_s2_q) begin
      mod_control_a_q <= fcp_pkg::CTRL_A_RST;
      mod_control_b_q <= fcp_pkg::CTRL_B_RST;
    end else if (reg_wr) begin
      if (reg_addr == fcp_pkg::ADDR_CTRL_A) begin
        mod_control_a_q <= reg_wdata;
      end
      if (reg_addr == fcp_pkg::ADDR_CTRL_B) begin
        mod_control_b_q <= reg_wdata;
      end
    end
  end

  // Shared data buffer: half select steers the write into a
  // per-channel low or upper staging byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_data_buffer_q <= 8'h00;
      for (int i = 0; i < NCH; i++) begin
        buf_lo_q[i] <= 8'h00;
        buf_hi_q[i] <= 6'h00;
      end
    end else if (reg_wr && reg_addr == fcp_pkg::ADDR_DBUF) begin
      mod_data_buffer_q <= reg_wdata;
      if (latch_half_select) begin
        buf_hi_q[channel_latch_select] <= reg_wdata[5:0];
      end else begin
        buf_lo_q[channel_latch_select] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        fcp_pkg::ADDR_CTRL_A: reg_rdata <= mod_control_a_q;
        fcp_pkg::ADDR_CTRL_B: reg_rdata <= mod_control_b_q;
        fcp_pkg::ADDR_DBUF:   reg_rdata <= mod_data_buffer_q;
        fcp_pkg::ADDR_STATUS: reg_rdata <= {4'h0, ~out_q};
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared free-running counter
  always_comb begin
    any_zero_lo = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (channel_run[i] && lat_lo_q[i] == fcp_pkg::BYTE_ZERO) begin
        any_zero_lo = 1'b1;
      end
    end
  end

  assign cnt_hold = stop_s2_q || mod_abort || channel_run == 4'h0 ||
                    any_zero_lo;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= fcp_pkg::CNT_ONES;
    end else if (cnt_hold) begin
      cnt_q <= fcp_pkg::CNT_ONES;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Staged values enter the active latch only at counter all ones;
  // a zero low byte still loads so the hold can be released
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        lat_lo_q[i]          <= 8'h00;
        mod_latch_upper_q[i] <= 6'h00;
      end
    end else if (cnt_q == fcp_pkg::CNT_ONES) begin
      for (int i = 0; i < NCH; i++) begin
        lat_lo_q[i]          <= buf_lo_q[i];
        mod_latch_upper_q[i] <= buf_hi_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extra-pulse slot decode: lowest set bit of the slot index picks
  // the upper bit, so upper bit k owns 2^k slots and m slots in all
  function automatic logic extra_hit(input logic [5:0] slot,
                                     input logic [5:0] upper,
                                     input logic       wide);
    int   w;
    logic found;
    logic hit;
    w     = wide ? fcp_pkg::SUB14_W : fcp_pkg::SUB12_W;
    found = 1'b0;
    hit   = 1'b0;
    for (int b = 0; b < fcp_pkg::SUB14_W; b++) begin
      if (b < w && !found && slot[b]) begin
        found = 1'b1;
        hit   = upper[w-1-b];
      end
    end
    extra_hit = hit;
  endfunction : extra_hit

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic       wide;
      logic [5:0] slot;
      logic [8:0] tick;
      logic [8:0] width;
      if (g < 2) begin : g_sel
        assign wide = channel_resolution_select[g];
      end else begin : g_fix
        assign wide = 1'b0;
      end
      // Unit is 2 or 4 core clocks; 256 units per sub-period
      always_comb begin
        if (clock_halve_select) begin
          tick = cnt_q[10:2];
          slot = wide ? cnt_q[15:10] : {2'h0, cnt_q[13:10]};
        end else begin
          tick = cnt_q[9:1];
          slot = wide ? cnt_q[14:9] : {2'h0, cnt_q[12:9]};
        end
      end
      assign width = {1'b0, lat_lo_q[g]} +
                     {8'h00, extra_hit(slot, mod_latch_upper_q[g], wide)};
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          out_q[g] <= 1'b1;
        end else if (stop_s2_q || mod_abort || !channel_run[g] ||
                     cnt_hold) begin
          out_q[g] <= 1'b1;
        end else begin
          out_q[g] <= !({1'b0, tick[7:0]} < width);
        end
      end
    end
  endgenerate

  assign mod_out_ch0 = out_q[0];
  assign mod_out_ch1 = out_q[1];
  assign mod_out_ch2 = out_q[2];
  assign mod_out_ch3 = out_q[3];

endmodule : fcp_top

// ### fcp_lpf_model.sv
// Filter stand-in: counts low cycles per pin.
// Assumes pins sampled on core_clk; clr zeroes all counts.
`timescale 1ns/1ps
module fcp_lpf_model (
  input  wire logic        core_clk,
  input  wire logic        clr,
  input  wire logic [3:0]  pin_n,
  output logic      [15:0] low_cnt [4]
);
  // Low time per window stands for the filtered level
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (clr) low_cnt[i] <= 16'h0000;
      else if (!pin_n[i]) low_cnt[i] <= low_cnt[i] + 16'h0001;
    end
  end
endmodule : fcp_lpf_model

// ### fcp_top_props.sv
// Port checker for fcp_top.
// Assumes one clock; bound below.
`timescale 1ns/1ps
module fcp_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       stop_mode,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       mod_out_ch0,
  input wire logic       mod_out_ch1,
  input wire logic       mod_out_ch2,
  input wire logic       mod_out_ch3
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic        hi;
  logic        prv_q;
  logic [15:0] gap_q;
  assign hi = mod_out_ch0 & mod_out_ch1 & mod_out_ch2 & mod_out_ch3;
  // Writes and STOP restart timing, so spacing is forgotten
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prv_q <= 1'b1;
      gap_q <= 16'hFFFF;
    end else begin
      prv_q <= mod_out_ch2;
      if (reg_wr || stop_mode) gap_q <= 16'hFFFF;
      else if (prv_q && !mod_out_ch2) gap_q <= 16'h0000;
      else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
    end
  end
  sequence s_stop_held;
    stop_mode [*4];
  endsequence
  sequence s_abort_wr;
    reg_wr && reg_addr == fcp_pkg::ADDR_CTRL_A
      && reg_wdata[fcp_pkg::ABORT_BIT];
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_stop_out_high: assert property (s_stop_held |-> hi)
    else $error("output low in stop");
  a_stop_ctrl_clear: assert property (s_stop_held ##0
    (reg_rd && reg_addr == fcp_pkg::ADDR_CTRL_A) |=> reg_rdata == 8'h00)
    else $error("control kept in stop");
  a_abort_all_high: assert property (s_abort_wr |-> ##2 hi [*2])
    else $error("abort left output low");
  a_idle_stays_high: assert property ((reg_wr
    && reg_addr == fcp_pkg::ADDR_CTRL_B && reg_wdata[7:4] == 4'h0)
    |-> ##2 hi [*3]) else $error("idle output low");
  a_high_gap_ch0: assert property ($rose(mod_out_ch0) |=> mod_out_ch0)
    else $error("short high on ch0");
  a_high_gap_ch3: assert property ($rose(mod_out_ch3) |=> mod_out_ch3)
    else $error("short high on ch3");
  a_sub_period_len: assert property ($fell(mod_out_ch2) |->
    gap_q == 16'd511 || gap_q == 16'd1023 || gap_q > 16'd1023)
    else $error("sub-period length wrong");
endmodule : fcp_chk
bind fcp_top fcp_chk u_chk (.core_clk, .rst_n, .stop_mode, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mod_out_ch0, .mod_out_ch1,
  .mod_out_ch2, .mod_out_ch3);

// ### tb_top.sv
// Bench for fcp_top: register tasks and low-time windows.
// Assumes fcp_lpf_model counts low cycles of each pin.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic        stop_mode = 1'b0;
  logic [1:0]  reg_addr  = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        clr       = 1'b0;
  logic [7:0]  reg_rdata;
  logic [3:0]  outs;
  logic [15:0] lo [4];
  int          bad_count  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  always #50 core_clk = ~core_clk;
  fcp_top dut (.core_clk, .rst_n, .stop_mode, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mod_out_ch0(outs[0]),
    .mod_out_ch1(outs[1]), .mod_out_ch2(outs[2]), .mod_out_ch3(outs[3]));
  fcp_lpf_model filt (.core_clk, .clr, .pin_n(outs), .low_cnt(lo));
  task automatic end_sim;
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #10 `CHK(reg_rdata, e)
  endtask : rd
  // Low byte first, then upper bits, each into its own per-channel staging byte
  task automatic ld(input logic [1:0] c, input logic [7:0] l, u);
    wr(fcp_pkg::ADDR_CTRL_B, {5'h00, c, 1'b0});
    wr(fcp_pkg::ADDR_DBUF, l);
    wr(fcp_pkg::ADDR_CTRL_B, {5'h00, c, 1'b1});
    wr(fcp_pkg::ADDR_DBUF, u);
  endtask : ld
  task automatic win(input int n);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (n) @(posedge core_clk);
    #10;
  endtask : win
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(fcp_pkg::ADDR_CTRL_A, fcp_pkg::CTRL_A_RST);
    rd(fcp_pkg::ADDR_CTRL_B, fcp_pkg::CTRL_B_RST);
    ld(2'h0, 8'h40, 8'h01);
    ld(2'h1, 8'h80, 8'h2A);
    ld(2'h2, 8'h10, 8'h0F);
    ld(2'h3, 8'hFF, 8'h00);
    #10;
    `CHK(outs, 4'hF)
    wr(fcp_pkg::ADDR_CTRL_A, 8'h02);
    wr(fcp_pkg::ADDR_CTRL_B, 8'hF0);
    win(32768);
    `CHK(lo[0], 16'h2008)
    `CHK(lo[1], 16'h4054)
    `CHK(lo[2], 16'h0878)
    `CHK(lo[3], 16'h7F80)
    wr(fcp_pkg::ADDR_CTRL_A, 8'h06);
    win(1000);
    `CHK(lo[3], 16'h0000)
    wr(fcp_pkg::ADDR_CTRL_A, 8'h0A);
    win(16384);
    `CHK(lo[0], 16'h1004)
    `CHK(lo[2], 16'h043C)
    `CHK(lo[3], 16'h3FC0)
    stop_mode <= 1'b1;
    win(5);
    `CHK(outs, 4'hF)
    rd(fcp_pkg::ADDR_CTRL_A, 8'h00);
    stop_mode <= 1'b0;
    repeat (5) @(posedge core_clk);
    rd(fcp_pkg::ADDR_CTRL_B, 8'h00);
    end_sim();
  end
endmodule : tb_top
